/* bench/link_checker.sv */
module link_checker (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Select and strobes
   input wire logic sel_n,
   input wire logic stat_read_strobe_n,
   input wire logic ctl_write_strobe_n,
   input wire logic xfer_strobe_inbound_n,
   input wire logic xfer_strobe_outbound_n,
   // Driver enables
   input wire logic csb_host_oe,
   input wire logic csb_dev_oe,
   input wire logic mb_host_oe,
   input wire logic mb_dev_oe,
   input wire logic req_in_oe,
   input wire logic req_out_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] low_cnt_r;
   logic [7:0] low_cnt_nxt;
   ////////////////////////////////////////////////////////////////////////////////
   // Read strobe length counter
   always_comb begin
      low_cnt_nxt = stat_read_strobe_n ? 8'h00 : low_cnt_r + 8'h01;
   end
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_cnt_r <= 8'h00;
      end else begin
         low_cnt_r <= low_cnt_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence read_start;
      $fell(stat_read_strobe_n) && !sel_n;
   endsequence
   sequence write_pulse;
      !ctl_write_strobe_n [*4] ##1 ctl_write_strobe_n;
   endsequence
   sequence ob_strobe;
      $fell(xfer_strobe_outbound_n) ##1 !xfer_strobe_outbound_n;
   endsequence
   sequence ib_strobe;
      $fell(xfer_strobe_inbound_n) ##1 !xfer_strobe_inbound_n;
   endsequence
   a_read_cycle_len:
   assert property ($rose(stat_read_strobe_n) |-> low_cnt_r == 8'h7D)
      else $error("read strobe length wrong");
   a_write_pulse_len:
   assert property ($fell(ctl_write_strobe_n) |-> write_pulse)
      else $error("write strobe length wrong");
   a_read_dev_drives:
   assert property (read_start |-> ##2 csb_dev_oe)
      else $error("device not driving read byte");
   a_dev_only_read:
   assert property (csb_dev_oe |-> !$past(stat_read_strobe_n) && !$past(sel_n))
      else $error("device drives status bus outside read");
   a_no_bus_fight:
   assert property (!(csb_dev_oe && csb_host_oe) && !(mb_dev_oe && mb_host_oe))
      else $error("two drivers on a bus");
   a_one_request:
   assert property (!(req_in_oe && req_out_oe))
      else $error("both request lines driven");
   a_outbound_host:
   assert property (ob_strobe |-> mb_host_oe)
      else $error("host not driving outbound byte");
   a_inbound_dev:
   assert property (ib_strobe |-> mb_dev_oe && !mb_host_oe)
      else $error("device not driving inbound byte");
   a_strobe_excl:
   assert property (xfer_strobe_inbound_n || xfer_strobe_outbound_n)
      else $error("both data strobes low");
   a_medium_off_csb:
   assert property (!(xfer_strobe_inbound_n && xfer_strobe_outbound_n)
                    |-> stat_read_strobe_n && ctl_write_strobe_n)
      else $error("status strobe during byte transfer");
endmodule

/* bench/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import link_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in;
   logic cmd_valid, cmd_ready, cmd_write, cmd_sel, rsp_valid, ob_valid, ob_ready, ib_valid;
   logic tx_valid, tx_ready, rx_valid;
   logic [ADDR_W-1:0] cmd_addr;
   logic [BYTE_W-1:0] cmd_wdata, rsp_rdata, ob_data, ib_data, tx_data, rx_data, status_val, rd;
   logic [BYTE_W-1:0] rxq[$];
   logic [BYTE_W-1:0] ibq[$];
   int bad_count = 0;
   int n_tests = 0;
   int n;
   link_if link_if_inst ();
   host_end host_end_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(link_if_inst),
      .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_write_in(cmd_write),
      .cmd_sel_in(cmd_sel), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
      .rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata), .ob_valid_in(ob_valid),
      .ob_ready_out(ob_ready), .ob_data_in(ob_data), .ib_valid_out(ib_valid),
      .ib_data_out(ib_data));
   device_end #(.MY_ID(1'b0)) device_end_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .link(link_if_inst), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
      .tx_data_in(tx_data), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
      .status_in(status_val));
   link_checker link_checker_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .sel_n(link_if_inst.sel_n), .stat_read_strobe_n(link_if_inst.stat_read_strobe_n),
      .ctl_write_strobe_n(link_if_inst.ctl_write_strobe_n),
      .xfer_strobe_inbound_n(link_if_inst.xfer_strobe_inbound_n),
      .xfer_strobe_outbound_n(link_if_inst.xfer_strobe_outbound_n),
      .csb_host_oe(link_if_inst.csb_host_oe), .csb_dev_oe(link_if_inst.csb_dev_oe),
      .mb_host_oe(link_if_inst.mb_host_oe), .mb_dev_oe(link_if_inst.mb_dev_oe),
      .req_in_oe(link_if_inst.req_in_oe), .req_out_oe(link_if_inst.req_out_oe));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, monitors, helpers
   initial begin
      forever #2 mclk_in = ~mclk_in;
   end
   always @(negedge mclk_in) begin
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
      if (ib_valid === 1'b1) ibq.push_back(ib_data);
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      if (bad_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic reg_op(input logic wr, input logic sel, input logic [5:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      int k;
      q = 8'h00;
      @(posedge mclk_in);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_sel <= sel;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(negedge mclk_in);
      for (k = 0; k < 300 && cmd_ready !== 1'b1; k++) @(negedge mclk_in);
      @(posedge mclk_in);
      cmd_valid <= 1'b0;
      if (!wr) begin
         k = 0;
         do begin
            @(negedge mclk_in);
            k++;
         end while (rsp_valid !== 1'b1 && k < 400);
         check(k[7:0], 8'h7E);
         q = rsp_rdata;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      reg_op(1'b0, 1'b0, SCRATCH_REG_ADDR, 8'h00, rd);
      check(rd, SCRATCH_RESET);
      reg_op(1'b0, 1'b0, DIR_REG_ADDR, 8'h00, rd);
      check(rd, DIR_RESET);
      reg_op(1'b1, 1'b0, STAT_REG_ADDR, 8'hFF, rd);
      reg_op(1'b0, 1'b0, STAT_REG_ADDR, 8'h00, rd);
      check(rd, 8'h3C);
      reg_op(1'b0, 1'b0, 6'h3F, 8'h00, rd);
      check(rd, 8'h00);
      reg_op(1'b1, 1'b0, SCRATCH_REG_ADDR, 8'hA5, rd);
      reg_op(1'b1, 1'b0, SCRATCH_REG_ADDR, 8'h5A, rd);
      reg_op(1'b0, 1'b0, SCRATCH_REG_ADDR, 8'h00, rd);
      check(rd, 8'h5A);
   endtask
   task automatic t_select();
      reg_op(1'b1, 1'b1, SCRATCH_REG_ADDR, 8'h99, rd);
      reg_op(1'b0, 1'b1, SCRATCH_REG_ADDR, 8'h00, rd);
      check(rd, 8'hFF);
      reg_op(1'b0, 1'b0, SCRATCH_REG_ADDR, 8'h00, rd);
      check(rd, 8'h5A);
   endtask
   task automatic t_outbound();
      int i;
      reg_op(1'b1, 1'b0, DIR_REG_ADDR, 8'h03, rd);
      for (n = 0; n < 40 && link_if_inst.xfer_req_outbound_n !== 1'b0; n++) @(negedge mclk_in);
      check({7'h00, link_if_inst.xfer_req_outbound_n}, 8'h00);
      check({7'h00, link_if_inst.xfer_req_inbound_n}, 8'h01);
      for (i = 0; i < 4; i++) begin
         @(posedge mclk_in);
         ob_valid <= 1'b1;
         ob_data <= 8'hC0 + 8'(i);
         @(negedge mclk_in);
         for (n = 0; n < 100 && ob_ready !== 1'b1; n++) @(negedge mclk_in);
         @(posedge mclk_in);
         ob_valid <= 1'b0;
      end
      for (n = 0; n < 200 && rxq.size() < 4; n++) @(negedge mclk_in);
      check(8'(rxq.size()), 8'h04);
      foreach (rxq[j]) check(rxq[j], 8'hC0 + 8'(j));
      reg_op(1'b0, 1'b0, COUNT_REG_ADDR, 8'h00, rd);
      check(rd, 8'h04);
      reg_op(1'b1, 1'b0, DIR_REG_ADDR, 8'h00, rd);
      for (n = 0; n < 40 && link_if_inst.xfer_req_outbound_n !== 1'b1; n++) @(negedge mclk_in);
      check({7'h00, link_if_inst.xfer_req_outbound_n}, 8'h01);
   endtask
   task automatic t_inbound();
      @(posedge mclk_in);
      tx_valid <= 1'b1;
      tx_data <= 8'h10;
      for (n = 0; n < 12; n++) begin
         @(negedge mclk_in);
         if (tx_ready !== 1'b1) break;
         @(posedge mclk_in);
         tx_data <= 8'h11 + 8'(n);
      end
      @(posedge mclk_in);
      tx_valid <= 1'b0;
      check(8'(n), 8'(FIFO_DEPTH));
      check({7'h00, link_if_inst.xfer_req_inbound_n}, 8'h01);
      reg_op(1'b1, 1'b0, DIR_REG_ADDR, 8'h01, rd);
      for (n = 0; n < 2000 && ibq.size() < 8; n++) @(negedge mclk_in);
      check(8'(ibq.size()), 8'h08);
      foreach (ibq[j]) check(ibq[j], 8'h10 + 8'(j));
      check({7'h00, tx_ready}, 8'h01);
      for (n = 0; n < 40 && link_if_inst.xfer_req_inbound_n !== 1'b1; n++) @(negedge mclk_in);
      check({7'h00, link_if_inst.xfer_req_inbound_n}, 8'h01);
      reg_op(1'b0, 1'b0, COUNT_REG_ADDR, 8'h00, rd);
      check(rd, 8'h0C);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      rst_n_in = 1'b0;
      {cmd_valid, cmd_write, cmd_sel, ob_valid, tx_valid} = 5'h00;
      {cmd_addr, cmd_wdata, ob_data, tx_data} = '0;
      status_val = 8'h3C;
      repeat (20) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      t_regs();
      t_select();
      t_outbound();
      t_inbound();
      repeat (10) @(posedge mclk_in);
      complete_run();
   end
   initial begin
      repeat (40000) @(posedge mclk_in);
      bad_count++;
      complete_run();
   end
endmodule

/* hw/byte_fifo.sv */
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   always_comb begin
      in_ready_out = (cnt_r != (AW+1)'(DEPTH));
      out_valid_out = (cnt_r != '0);
      out_data_out = mem_r[rp_r];
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      wp_nxt = push ? bump(wp_r) : wp_r;
      rp_nxt = pop ? bump(rp_r) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem_r[wp_r] <= in_data_in;
      end
   end
endmodule

/* hw/device_end.sv */
module device_end
   import link_pkg::*;
#(
   parameter logic MY_ID = 1'b0
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Link
   link_if.device link,
   // Inbound medium bytes from user (device to host)
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic [BYTE_W-1:0] tx_data_in,
   // Outbound medium bytes to user (host to device)
   output logic rx_valid_out,
   output logic [BYTE_W-1:0] rx_data_out,
   // Status from user
   input wire logic [BYTE_W-1:0] status_in
);
   typedef enum {D_IDLE, D_REQ, D_WAIT_END} dstate_t;
   dstate_t st_r, st_nxt;
   logic [BYTE_W-1:0] dir_r, dir_nxt, scr_r, scr_nxt, cnt_r, cnt_nxt;
   logic [BYTE_W-1:0] rd_r, rd_nxt, rx_r, rx_nxt;
   logic rd_oe_r, rd_oe_nxt, rxv_r, rxv_nxt;
   logic ws_d_r, ss_in_d_r, ss_out_d_r;
   logic sel, wr_edge, rd_act, si_fall, so_fall, si_rise, so_rise;
   logic fifo_v, fifo_rdy;
   logic [BYTE_W-1:0] fifo_d;
   logic en, outb;

   //////////////////////////////////////////////////////////////////////
   // Outgoing byte buffer
   byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(tx_valid_in),
      .in_ready_out(tx_ready_out),
      .in_data_in(tx_data_in),
      .out_valid_out(fifo_v),
      .out_ready_in(fifo_rdy),
      .out_data_out(fifo_d)
   );

   //////////////////////////////////////////////////////////////////////
   // Control/status registers
   function automatic logic [BYTE_W-1:0] reg_read(input logic [ADDR_W-1:0] a);
      case (a)
         DIR_REG_ADDR: reg_read = dir_r;
         STAT_REG_ADDR: reg_read = status_in;
         SCRATCH_REG_ADDR: reg_read = scr_r;
         COUNT_REG_ADDR: reg_read = cnt_r;
         default: reg_read = 8'h00;
      endcase
   endfunction

   always_comb begin
      sel = (link.sel_n == MY_ID);
      en = dir_r[DIR_ENABLE_BIT];
      outb = dir_r[DIR_OUTBOUND_BIT];
      wr_edge = sel && !link.ctl_write_strobe_n && ws_d_r;
      rd_act = sel && !link.stat_read_strobe_n;
      si_fall = !link.xfer_strobe_inbound_n && ss_in_d_r;
      so_fall = !link.xfer_strobe_outbound_n && ss_out_d_r;
      si_rise = link.xfer_strobe_inbound_n && !ss_in_d_r;
      so_rise = link.xfer_strobe_outbound_n && !ss_out_d_r;
      dir_nxt = dir_r;
      scr_nxt = scr_r;
      cnt_nxt = cnt_r;
      rd_nxt = rd_r;
      rd_oe_nxt = rd_act;
      if (rd_act) begin
         rd_nxt = reg_read(link.reg_addr_lines);
      end
      if (wr_edge) begin
         case (link.reg_addr_lines)
            DIR_REG_ADDR: dir_nxt = link.ctl_stat_byte_bus;
            SCRATCH_REG_ADDR: scr_nxt = link.ctl_stat_byte_bus;
            default: ;
         endcase
      end
      st_nxt = st_r;
      fifo_rdy = 1'b0;
      rx_nxt = rx_r;
      rxv_nxt = 1'b0;
      case (st_r)
         D_IDLE: begin
            if (en && (outb || fifo_v)) begin
               st_nxt = D_REQ;
            end
         end
         D_REQ: begin
            if (!en) begin
               st_nxt = D_IDLE;
            end else if (outb && so_fall) begin
               rx_nxt = link.medium_byte_bus;
               rxv_nxt = 1'b1;
               st_nxt = D_WAIT_END;
            end else if (!outb && si_fall) begin
               st_nxt = D_WAIT_END;
            end
         end
         D_WAIT_END: begin
            if (outb ? so_rise : si_rise) begin
               fifo_rdy = !outb;
               cnt_nxt = cnt_r + 8'h01;
               st_nxt = D_IDLE;
            end
         end
         default: st_nxt = D_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= D_IDLE;
         dir_r <= DIR_RESET;
         scr_r <= SCRATCH_RESET;
         cnt_r <= 8'h00;
         rd_r <= 8'h00;
         rd_oe_r <= 1'b0;
         rx_r <= 8'h00;
         rxv_r <= 1'b0;
         ws_d_r <= 1'b1;
         ss_in_d_r <= 1'b1;
         ss_out_d_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         dir_r <= dir_nxt;
         scr_r <= scr_nxt;
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
         rd_oe_r <= rd_oe_nxt;
         rx_r <= rx_nxt;
         rxv_r <= rxv_nxt;
         ws_d_r <= link.ctl_write_strobe_n;
         ss_in_d_r <= link.xfer_strobe_inbound_n;
         ss_out_d_r <= link.xfer_strobe_outbound_n;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Pin drivers
   always_comb begin
      link.csb_dev_o = rd_r;
      link.csb_dev_oe = rd_oe_r && sel && !link.stat_read_strobe_n;
      link.mb_dev_o = fifo_d;
      link.mb_dev_oe = !outb && en && (st_r != D_IDLE) && !link.xfer_strobe_inbound_n;
      link.req_in_o = !(st_r == D_REQ);
      link.req_in_oe = en && !outb;
      link.req_out_o = !(st_r == D_REQ);
      link.req_out_oe = en && outb;
      rx_valid_out = rxv_r;
      rx_data_out = rx_r;
   end
endmodule

/* hw/host_end.sv */
module host_end
   import link_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Link
   link_if.host link,
   // Register command
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic cmd_write_in,
   input wire logic cmd_sel_in,
   input wire logic [ADDR_W-1:0] cmd_addr_in,
   input wire logic [BYTE_W-1:0] cmd_wdata_in,
   output logic rsp_valid_out,
   output logic [BYTE_W-1:0] rsp_rdata_out,
   // Outbound medium bytes
   input wire logic ob_valid_in,
   output logic ob_ready_out,
   input wire logic [BYTE_W-1:0] ob_data_in,
   // Inbound medium bytes
   output logic ib_valid_out,
   output logic [BYTE_W-1:0] ib_data_out
);
   typedef enum {H_IDLE, H_READ, H_WRITE, H_XIN, H_XOUT} hstate_t;
   hstate_t st_r, st_nxt;
   logic [7:0] tmr_r, tmr_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic sel_r, sel_nxt;
   logic [BYTE_W-1:0] wd_r, wd_nxt, rsp_r, rsp_nxt, ib_r, ib_nxt;
   logic rspv_r, rspv_nxt, ibv_r, ibv_nxt;

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r;
      addr_nxt = addr_r;
      sel_nxt = sel_r;
      wd_nxt = wd_r;
      rsp_nxt = rsp_r;
      rspv_nxt = 1'b0;
      ib_nxt = ib_r;
      ibv_nxt = 1'b0;
      cmd_ready_out = (st_r == H_IDLE);
      ob_ready_out = 1'b0;
      case (st_r)
         H_IDLE: begin
            if (cmd_valid_in) begin
               addr_nxt = cmd_addr_in;
               sel_nxt = cmd_sel_in;
               wd_nxt = cmd_wdata_in;
               st_nxt = cmd_write_in ? H_WRITE : H_READ;
               tmr_nxt = cmd_write_in ? 8'(STROBE_CYCLES) : 8'(READ_CYCLES);
            end else if (!link.xfer_req_outbound_n && ob_valid_in) begin
               ob_ready_out = 1'b1;
               wd_nxt = ob_data_in;
               st_nxt = H_XOUT;
               tmr_nxt = 8'(STROBE_CYCLES);
            end else if (!link.xfer_req_inbound_n) begin
               st_nxt = H_XIN;
               tmr_nxt = 8'(STROBE_CYCLES);
            end
         end
         H_READ, H_WRITE, H_XIN, H_XOUT: begin
            tmr_nxt = tmr_r - 8'h01;
            if (tmr_r == 8'h01) begin
               if (st_r == H_READ) begin
                  rsp_nxt = link.ctl_stat_byte_bus;
                  rspv_nxt = 1'b1;
               end
               if (st_r == H_XIN) begin
                  ib_nxt = link.medium_byte_bus;
                  ibv_nxt = 1'b1;
               end
               st_nxt = H_IDLE;
            end
         end
         default: st_nxt = H_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= H_IDLE;
         tmr_r <= 8'h00;
         addr_r <= '0;
         sel_r <= 1'b0;
         wd_r <= 8'h00;
         rsp_r <= 8'h00;
         rspv_r <= 1'b0;
         ib_r <= 8'h00;
         ibv_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         addr_r <= addr_nxt;
         sel_r <= sel_nxt;
         wd_r <= wd_nxt;
         rsp_r <= rsp_nxt;
         rspv_r <= rspv_nxt;
         ib_r <= ib_nxt;
         ibv_r <= ibv_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Pin drivers
   always_comb begin
      link.reg_addr_lines = addr_r;
      link.sel_n = sel_r;
      link.stat_read_strobe_n = !(st_r == H_READ);
      link.ctl_write_strobe_n = !(st_r == H_WRITE);
      link.csb_host_o = wd_r;
      link.csb_host_oe = (st_r == H_WRITE);
      link.mb_host_o = wd_r;
      link.mb_host_oe = (st_r == H_XOUT);
      link.xfer_strobe_inbound_n = !(st_r == H_XIN);
      link.xfer_strobe_outbound_n = !(st_r == H_XOUT);
      rsp_valid_out = rspv_r;
      rsp_rdata_out = rsp_r;
      ib_valid_out = ibv_r;
      ib_data_out = ib_r;
   end
endmodule

/* hw/link_if.sv */
interface link_if;
   import link_pkg::*;
   logic [ADDR_W-1:0] reg_addr_lines;
   logic sel_n;
   logic stat_read_strobe_n;
   logic ctl_write_strobe_n;
   logic [BYTE_W-1:0] csb_host_o;
   logic csb_host_oe;
   logic [BYTE_W-1:0] csb_dev_o;
   logic csb_dev_oe;
   logic [BYTE_W-1:0] ctl_stat_byte_bus;
   logic [BYTE_W-1:0] mb_host_o;
   logic mb_host_oe;
   logic [BYTE_W-1:0] mb_dev_o;
   logic mb_dev_oe;
   logic [BYTE_W-1:0] medium_byte_bus;
   logic req_in_o;
   logic req_in_oe;
   logic req_out_o;
   logic req_out_oe;
   logic xfer_req_inbound_n;
   logic xfer_req_outbound_n;
   logic xfer_strobe_inbound_n;
   logic xfer_strobe_outbound_n;
   // Wire resolution; released lines pull high
   assign ctl_stat_byte_bus = csb_dev_oe ? csb_dev_o : (csb_host_oe ? csb_host_o : 8'hFF);
   assign medium_byte_bus = mb_dev_oe ? mb_dev_o : (mb_host_oe ? mb_host_o : 8'hFF);
   assign xfer_req_inbound_n = req_in_oe ? req_in_o : 1'b1;
   assign xfer_req_outbound_n = req_out_oe ? req_out_o : 1'b1;
   modport host (
      output reg_addr_lines, sel_n, stat_read_strobe_n, ctl_write_strobe_n,
      output csb_host_o, csb_host_oe, mb_host_o, mb_host_oe,
      output xfer_strobe_inbound_n, xfer_strobe_outbound_n,
      input ctl_stat_byte_bus, medium_byte_bus, xfer_req_inbound_n, xfer_req_outbound_n
   );
   modport device (
      input reg_addr_lines, sel_n, stat_read_strobe_n, ctl_write_strobe_n,
      input xfer_strobe_inbound_n, xfer_strobe_outbound_n,
      input ctl_stat_byte_bus, medium_byte_bus,
      output csb_dev_o, csb_dev_oe, mb_dev_o, mb_dev_oe,
      output req_in_o, req_in_oe, req_out_o, req_out_oe
   );
endinterface

/* hw/link_pkg.sv */
// Summary of operation
// - Host drives six-bit register address
// - Eight-bit two-way control/status byte bus
// - Read strobe returns addressed register byte
// - Each read strobe is 500 ns cycle
// - Write strobe loads control byte into register
// - Medium bytes never use control/status bus
// - Separate eight-bit two-way medium byte bus
// - Device requests bytes on tri-state request lines
// - Outbound means host to device, inbound reverse
// - Device drives request line chosen by write
// - Host generates both data strobes
// - Select low chooses device controller zero
package link_pkg;
   localparam int ADDR_W = 6;
   localparam int BYTE_W = 8;
   localparam int CLK_PERIOD_NS = 4;
   localparam int READ_CYCLE_NS = 500;
   localparam int READ_CYCLES = READ_CYCLE_NS / CLK_PERIOD_NS;
   localparam int STROBE_CYCLES = 4;
   localparam int NUM_REGS = 4;
   localparam logic [5:0] DIR_REG_ADDR = 6'h00;
   localparam logic [5:0] STAT_REG_ADDR = 6'h01;
   localparam logic [5:0] SCRATCH_REG_ADDR = 6'h02;
   localparam logic [5:0] COUNT_REG_ADDR = 6'h03;
   localparam int DIR_ENABLE_BIT = 0;
   localparam int DIR_OUTBOUND_BIT = 1;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] SCRATCH_RESET = 8'h00;
   localparam int FIFO_DEPTH = 8;
endpackage
